// File: rtl/timer16_pkg.sv
// constants, field layouts and types for the buffered sixteen-bit counter
// ****************************************************************
// ****************************************************************
package timer16_pkg;

  // ****************************************************************
  // register byte addresses, one aligned word each
  // ****************************************************************
  localparam logic [7:0] OFF_COUNT_LOW = 8'h00;
  localparam logic [7:0] OFF_COUNT_HIGH = 8'h04;
  localparam logic [7:0] OFF_CONTROL = 8'h08;
  localparam logic [7:0] OFF_AUX_CONTROL = 8'h0C;
  localparam logic [7:0] OFF_FLAG_TWO = 8'h10;
  localparam logic [7:0] OFF_ENABLE_TWO = 8'h14;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int OSC_EN_BIT = 3; // aux oscillator enable in aux control
  localparam int OVF_BIT = 1; // overflow flag and its enable

  // ****************************************************************
  // values after reset and fixed codes
  // ****************************************************************
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [3:0] TRIGGER_MODE = 4'hB; // compare with special event trigger
  localparam int PRESC_W = 3; // enough for divide by eight
  localparam logic [PRESC_W-1:0] PRESC_RESET = 3'h0;

  // control register layout, bit 7 first
  typedef struct packed {
    logic buf_en; // buffered access enable
    logic assign_two; // compare two drives this counter
    logic [1:0] presc_sel; // prescale select hi, lo
    logic assign_one; // compare one drives this counter
    logic sync_sel; // sync select
    logic ext_sel; // external clock select
    logic run_en; // count run enable
  } ctrl_t;

endpackage

// File: rtl/sixteen_bit_timer_buffered.sv
// sixteen-bit up-counter with buffered high byte on a classic wishbone slave
`timescale 1ns/1ps
module sixteen_bit_timer_buffered
  import timer16_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // clock source pins
  input wire logic ext_clk_i,
  input wire logic aux_osc_clk_i,
  // compare units, same clock domain
  input wire logic [3:0] compare_one_mode_i,
  input wire logic compare_one_trigger_i,
  input wire logic [3:0] compare_two_mode_i,
  input wire logic compare_two_trigger_i,
  // status out
  output logic [15:0] count_o,
  output logic irq_o
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic [15:0] count_reg; // live counter
  logic [7:0] buffer_reg; // high byte holding buffer
  ctrl_t ctrl_reg; // counter control
  logic aux_osc_en_reg; // aux oscillator enable
  logic flag_reg; // sticky overflow flag
  logic irq_en_reg; // overflow interrupt enable
  logic [PRESC_W-1:0] presc_reg; // prescaler count
  logic ack_reg; // bus answer
  logic [31:0] rd_data_reg; // bus read data
  // synchroniser stages; the meta stage feeds only the next flop
  logic ext_meta_reg;
  logic ext_sync_reg;
  logic ext_prev_reg;
  logic aux_meta_reg;
  logic aux_sync_reg;
  logic aux_prev_reg;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  logic access; // request seen, not yet answered
  logic wr_en; // write taken this edge
  logic rd_en; // read taken this edge
  logic [7:0] wdata; // written byte
  logic wr_low;
  logic wr_high;
  logic rd_low;
  logic rd_high;
  logic [31:0] rd_data_next;

  assign access = wb_cyc_i & wb_stb_i & ~ack_reg;
  // only lane zero carries the byte-wide registers
  assign wr_en = access & wb_we_i & wb_sel_i[0];
  assign rd_en = access & ~wb_we_i;
  assign wdata = wb_dat_i[7:0];
  assign wr_low = wr_en & (wb_adr_i == OFF_COUNT_LOW);
  assign wr_high = wr_en & (wb_adr_i == OFF_COUNT_HIGH);
  assign rd_low = rd_en & (wb_adr_i == OFF_COUNT_LOW);
  assign rd_high = rd_en & (wb_adr_i == OFF_COUNT_HIGH);

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= access;
    end
  end

  // read mux; unmapped addresses read zero and still answer
  always_comb begin
    rd_data_next = 32'h0000_0000;
    unique case (wb_adr_i)
      OFF_COUNT_LOW: begin
        rd_data_next[7:0] = count_reg[7:0];
      end
      OFF_COUNT_HIGH: begin
        // buffered mode never exposes the live high byte
        rd_data_next[7:0] = ctrl_reg.buf_en ? buffer_reg : count_reg[15:8];
      end
      OFF_CONTROL: begin
        rd_data_next[7:0] = ctrl_reg;
      end
      OFF_AUX_CONTROL: begin
        rd_data_next[OSC_EN_BIT] = aux_osc_en_reg;
      end
      OFF_FLAG_TWO: begin
        rd_data_next[OVF_BIT] = flag_reg;
      end
      OFF_ENABLE_TWO: begin
        rd_data_next[OVF_BIT] = irq_en_reg;
      end
      default: begin
        rd_data_next = 32'h0000_0000;
      end
    endcase
  end

  // read data registered alongside ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_reg <= 32'h0000_0000;
    end else if (rd_en) begin
      rd_data_reg <= rd_data_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rd_data_reg;

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  // control and enables; writes take effect at the request edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= CONTROL_RESET;
      aux_osc_en_reg <= 1'b0;
      irq_en_reg <= 1'b0;
    end else if (wr_en) begin
      if (wb_adr_i == OFF_CONTROL) begin
        ctrl_reg <= wdata;
      end
      if (wb_adr_i == OFF_AUX_CONTROL) begin
        aux_osc_en_reg <= wdata[OSC_EN_BIT];
      end
      if (wb_adr_i == OFF_ENABLE_TWO) begin
        irq_en_reg <= wdata[OVF_BIT];
      end
    end
  end

  // ****************************************************************
  // clock source selection
  // ****************************************************************
  // pins are asynchronous: two flops, then a third for the edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_meta_reg <= 1'b0;
      ext_sync_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
      aux_meta_reg <= 1'b0;
      aux_sync_reg <= 1'b0;
      aux_prev_reg <= 1'b0;
    end else begin
      ext_meta_reg <= ext_clk_i;
      ext_sync_reg <= ext_meta_reg;
      ext_prev_reg <= ext_sync_reg;
      aux_meta_reg <= aux_osc_clk_i;
      aux_sync_reg <= aux_meta_reg;
      aux_prev_reg <= aux_sync_reg;
    end
  end

  logic ext_rise; // rising edge of the external pin
  logic aux_rise; // rising edge of the oscillator
  logic src_tick; // one advance of the selected source
  assign ext_rise = ext_sync_reg & ~ext_prev_reg;
  assign aux_rise = aux_sync_reg & ~aux_prev_reg;

  // the sync select bit changes nothing here: every source is
  // resynchronised, so the counter always behaves synchronously
  always_comb begin
    if (!ctrl_reg.ext_sel) begin
      src_tick = 1'b1; // system clock
    end else if (aux_osc_en_reg) begin
      src_tick = aux_rise;
    end else begin
      src_tick = ext_rise;
    end
  end

  // ****************************************************************
  // prescaler
  // ****************************************************************
  logic [PRESC_W-1:0] presc_limit; // last count before a tick
  logic presc_tick; // counter advances this edge
  assign presc_limit = PRESC_W'((4'h1 << ctrl_reg.presc_sel) - 4'h1);
  assign presc_tick = ctrl_reg.run_en & src_tick & (presc_reg == presc_limit);

  // cleared by low writes only; high writes leave it alone
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      presc_reg <= PRESC_RESET;
    end else if (wr_low) begin
      presc_reg <= PRESC_RESET;
    end else if (ctrl_reg.run_en && src_tick) begin
      presc_reg <= presc_tick ? PRESC_RESET : presc_reg + 3'h1;
    end
  end

  // ****************************************************************
  // compare triggers
  // ****************************************************************
  logic trig_one;
  logic trig_two;
  logic trig_reset; // zero the count this edge
  logic count_write; // software touches the live count
  assign trig_one = compare_one_trigger_i & ctrl_reg.assign_one & (compare_one_mode_i == TRIGGER_MODE);
  // compare two value becomes the period when it resets us
  assign trig_two = compare_two_trigger_i & ctrl_reg.assign_two & (compare_two_mode_i == TRIGGER_MODE);
  assign trig_reset = trig_one | trig_two;
  assign count_write = wr_low | (wr_high & ~ctrl_reg.buf_en);

  // ****************************************************************
  // counter and holding buffer
  // ****************************************************************
  logic ovf_evt; // genuine wrap, never a trigger
  assign ovf_evt = presc_tick & (count_reg == COUNT_MAX) & ~count_write & ~trig_reset;

  // priority: write, trigger, count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_reg <= COUNT_RESET;
    end else if (wr_low) begin
      // buffered: all sixteen bits land together
      count_reg <= {ctrl_reg.buf_en ? buffer_reg : count_reg[15:8], wdata};
    end else if (wr_high && !ctrl_reg.buf_en) begin
      count_reg[15:8] <= wdata;
    end else if (trig_reset) begin
      count_reg <= COUNT_RESET;
    end else if (presc_tick) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  // in buffered mode the buffer catches high writes and snapshots on low reads
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      buffer_reg <= BYTE_RESET;
    end else if (wr_high && ctrl_reg.buf_en) begin
      buffer_reg <= wdata;
    end else if (rd_low && ctrl_reg.buf_en) begin
      buffer_reg <= count_reg[15:8];
    end
  end

  assign count_o = count_reg;

  // ****************************************************************
  // interrupt
  // ****************************************************************
  logic flag_clr; // write one to clear
  assign flag_clr = wr_en & (wb_adr_i == OFF_FLAG_TWO) & wdata[OVF_BIT];

  // a wrap in the clearing cycle still sets the flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= (flag_reg & ~flag_clr) | ovf_evt;
    end
  end

  assign irq_o = flag_reg & irq_en_reg;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_wrap_sets_flag;
    ovf_evt |=> (count_reg == COUNT_RESET) && flag_reg;
  endproperty
  a_wrap_sets_flag: assert property (p_wrap_sets_flag) else $error("wrap did not zero count and set flag");

  property p_flag_sticky;
    flag_reg && !flag_clr |=> flag_reg;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("overflow flag dropped without clear");

  property p_irq_masked;
    !irq_en_reg |-> !irq_o;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("interrupt raised while masked");

  property p_high_write_to_buffer;
    wr_high && ctrl_reg.buf_en |=> buffer_reg == $past(wdata);
  endproperty
  a_high_write_to_buffer: assert property (p_high_write_to_buffer) else $error("buffered high write missed buffer");

  property p_low_read_snapshot;
    rd_low && ctrl_reg.buf_en |=> buffer_reg == $past(count_reg[15:8]);
  endproperty
  a_low_read_snapshot: assert property (p_low_read_snapshot) else $error("low read did not snapshot high");

  property p_low_write_loads_high;
    wr_low && ctrl_reg.buf_en |=> count_reg == {$past(buffer_reg), $past(wdata)};
  endproperty
  a_low_write_loads_high: assert property (p_low_write_loads_high) else $error("low write did not load 16 bits");

  property p_high_read_buffer;
    rd_high && ctrl_reg.buf_en |=> wb_ack_o && wb_dat_o[7:0] == $past(buffer_reg);
  endproperty
  a_high_read_buffer: assert property (p_high_read_buffer) else $error("buffered high read saw live byte");

  property p_low_write_clears_presc;
    wr_low |=> presc_reg == PRESC_RESET;
  endproperty
  a_low_write_clears_presc: assert property (p_low_write_clears_presc) else $error("prescaler not cleared");

  property p_osc_idle_holds;
    ctrl_reg.ext_sel && aux_osc_en_reg && !aux_rise && !count_write && !trig_reset && !wr_en
      |=> count_reg == $past(count_reg);
  endproperty
  a_osc_idle_holds: assert property (p_osc_idle_holds) else $error("counted without oscillator edge");

  property p_trigger_zeroes;
    trig_reset && !count_write |=> count_reg == COUNT_RESET;
  endproperty
  a_trigger_zeroes: assert property (p_trigger_zeroes) else $error("trigger did not zero count");

  property p_write_beats_trigger;
    trig_reset && wr_low |=> count_reg[7:0] == $past(wdata);
  endproperty
  a_write_beats_trigger: assert property (p_write_beats_trigger) else $error("trigger beat software write");

  property p_trigger_no_flag;
    trig_reset && !flag_reg |=> !flag_reg;
  endproperty
  a_trigger_no_flag: assert property (p_trigger_no_flag) else $error("trigger set overflow flag");

  property p_stopped_holds;
    !ctrl_reg.run_en && !count_write && !trig_reset |=> count_reg == $past(count_reg);
  endproperty
  a_stopped_holds: assert property (p_stopped_holds) else $error("counter moved while stopped");

  property p_div8_spacing;
    presc_tick && ctrl_reg.presc_sel == 2'b11 && !ctrl_reg.ext_sel |=> !presc_tick [*7];
  endproperty
  a_div8_spacing: assert property (p_div8_spacing) else $error("divide by eight ticked early");

  property p_ack_one_cycle;
    access |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_one_cycle: assert property (p_ack_one_cycle) else $error("ack not a single cycle after request");

  property p_irq_raised;
    flag_reg && irq_en_reg |-> irq_o;
  endproperty
  a_irq_raised: assert property (p_irq_raised) else $error("interrupt missing while enabled");

  property p_flag_clears;
    flag_clr && !ovf_evt |=> !flag_reg;
  endproperty
  a_flag_clears: assert property (p_flag_clears) else $error("overflow flag not cleared");

  // a high write may not disturb the divider; only source ticks move it
  property p_high_write_keeps_presc;
    wr_high && !(ctrl_reg.run_en && src_tick) |=> presc_reg == $past(presc_reg);
  endproperty
  a_high_write_keeps_presc: assert property (p_high_write_keeps_presc) else $error("prescaler moved");

  property p_live_high_hidden;
    wr_high && ctrl_reg.buf_en && !presc_tick && !trig_reset |=> count_reg == $past(count_reg);
  endproperty
  a_live_high_hidden: assert property (p_live_high_hidden) else $error("live high byte written");

  c_overflow: cover property (ovf_evt ##1 irq_o);
  c_trigger: cover property (trig_two && presc_tick);
  c_buffered_read: cover property (rd_low && ctrl_reg.buf_en ##[1:20] rd_high);
  c_set_during_clear: cover property (ovf_evt && flag_clr);
  c_write_beats_trigger: cover property (trig_reset && wr_low);

endmodule

// File: test/compare_unit_model.sv
// far-side model of the second compare unit used as a period register
`timescale 1ns/1ps
module compare_unit_model
  import timer16_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // setup from the bench
  input wire logic enable_i,
  input wire logic [15:0] period_i,
  // live count seen from the counter
  input wire logic [15:0] count_i,
  // compare unit outputs
  output logic [3:0] mode_o,
  output logic trigger_o
);
  // ****************************************************************
  // compare logic
  // ****************************************************************
  // trigger mode only while enabled, idle code otherwise
  assign mode_o = enable_i ? TRIGGER_MODE : 4'h0;
  // match fires in the same cycle, so the pair becomes the period
  // no clock-domain work here: unit shares the counter clock
  assign trigger_o = enable_i && !rst_i && (count_i == period_i);
endmodule

// File: test/sixteen_bit_timer_buffered_tb_top.sv
// self-checking bench for the buffered sixteen-bit counter
`timescale 1ns/1ps
module sixteen_bit_timer_buffered_tb_top
  import timer16_pkg::*;
;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat_w = 32'h0000_0000;
  logic [31:0] wb_dat_r;
  logic wb_ack, irq, c2_trig;
  logic ext_clk = 1'b0, aux_clk = 1'b0, cmp_en = 1'b0;
  logic [3:0] c1_mode = 4'h0;
  logic c1_trig = 1'b0;
  logic [3:0] c2_mode;
  logic [15:0] period = 16'h0014;
  logic [15:0] count, c0, cmax;
  ctrl_t cfg;
  int bad_count = 0;
  int total_checks = 0;
  int s;
  // 100 MHz clock
  always #5 clk_i = ~clk_i;
  sixteen_bit_timer_buffered sixteen_bit_timer_buffered_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r),
    .wb_ack_o(wb_ack), .ext_clk_i(ext_clk), .aux_osc_clk_i(aux_clk),
    .compare_one_mode_i(c1_mode), .compare_one_trigger_i(c1_trig),
    .compare_two_mode_i(c2_mode), .compare_two_trigger_i(c2_trig),
    .count_o(count), .irq_o(irq));
  compare_unit_model compare_unit_model_inst (
    .clk_i(clk_i), .rst_i(rst_i), .enable_i(cmp_en), .period_i(period),
    .count_i(count), .mode_o(c2_mode), .trigger_o(c2_trig));
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // compare and count
  task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one classic cycle; request held until ack is sampled high
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_sel <= 4'hF;
    wb_dat_w <= {24'h00_0000, d};
    for (n = 0; n < 16; n++) begin
      @(posedge clk_i);
      if (wb_ack === 1'b1) break;
    end
    q = wb_dat_r[7:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (n == 16) begin
      bad_count++;
      $display("MISMATCH wb_ack expected 1 seen 0");
      summarize();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb_xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    wb_xfer(1'b0, a, 8'h00, q);
    check(nm, {8'h00, exp}, {8'h00, q});
  endtask
  // pulses on the pins, each level held four clocks, then settle
  task automatic pulses(input logic e, input logic a, input int n);
    repeat (n) begin
      ext_clk <= e;
      aux_clk <= a;
      repeat (4) @(posedge clk_i);
      ext_clk <= 1'b0;
      aux_clk <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
    repeat (6) @(posedge clk_i);
  endtask
  // track the largest count over a number of clocks
  task automatic watch(input int n);
    cmax = 16'h0000;
    repeat (n) begin
      @(posedge clk_i);
      if (count > cmax) cmax = count;
    end
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values and an unmapped place
    rd("control", OFF_CONTROL, 8'h00);
    rd("flag", OFF_FLAG_TWO, 8'h00);
    rd("unmapped", 8'h20, 8'h00);
    wr(OFF_CONTROL, 8'hA4);
    rd("control_rw", OFF_CONTROL, 8'hA4);
    $display("test registers done");
    // prescale ratios, then hold while stopped
    for (s = 0; s < 4; s++) begin
      cfg = '0;
      cfg.presc_sel = s[1:0];
      cfg.run_en = 1'b1;
      wr(OFF_CONTROL, cfg);
      repeat (16) @(posedge clk_i);
      c0 = count;
      repeat (64) @(posedge clk_i);
      check("prescale", 16'(64 >> s), count - c0);
    end
    wr(OFF_CONTROL, 8'h00);
    c0 = count;
    repeat (20) @(posedge clk_i);
    check("stopped", c0, count);
    $display("test prescale done");
    // buffered load near the top, then overflow and interrupt
    cfg = '0;
    cfg.buf_en = 1'b1;
    wr(OFF_CONTROL, cfg);
    c0 = count;
    wr(OFF_COUNT_HIGH, 8'hFF);
    check("high_hidden", c0, count);
    wr(OFF_COUNT_LOW, 8'hF0);
    check("load16", 16'hFFF0, count);
    cfg.run_en = 1'b1;
    wr(OFF_CONTROL, cfg);
    repeat (40) @(posedge clk_i);
    cfg.run_en = 1'b0;
    wr(OFF_CONTROL, cfg);
    rd("flag_set", OFF_FLAG_TWO, 8'h02);
    check("irq_masked", 16'h0000, {15'h0000, irq});
    wr(OFF_ENABLE_TWO, 8'h02);
    check("irq_on", 16'h0001, {15'h0000, irq});
    wr(OFF_FLAG_TWO, 8'h02);
    rd("flag_clr", OFF_FLAG_TWO, 8'h00);
    check("irq_off", 16'h0000, {15'h0000, irq});
    $display("test overflow done");
    // coherent read through the holding buffer
    wr(OFF_COUNT_HIGH, 8'h12);
    wr(OFF_COUNT_LOW, 8'h34);
    wr(OFF_COUNT_HIGH, 8'h99);
    rd("buf_back", OFF_COUNT_HIGH, 8'h99);
    rd("low", OFF_COUNT_LOW, 8'h34);
    rd("snap", OFF_COUNT_HIGH, 8'h12);
    wr(OFF_CONTROL, 8'h00);
    rd("live_high", OFF_COUNT_HIGH, 8'h12);
    wr(OFF_COUNT_HIGH, 8'h77);
    check("direct", 16'h7734, count);
    $display("test buffer done");
    // compare two trigger acting as a period, timer mode
    wr(OFF_COUNT_HIGH, 8'h00);
    wr(OFF_COUNT_LOW, 8'h00);
    cmp_en <= 1'b1;
    cfg = '0;
    cfg.assign_two = 1'b1;
    cfg.run_en = 1'b1;
    wr(OFF_CONTROL, cfg);
    watch(200);
    check("period", period, cmax);
    rd("no_flag", OFF_FLAG_TWO, 8'h00);
    cfg.assign_two = 1'b0;
    wr(OFF_CONTROL, cfg);
    watch(60);
    check("unassigned", 16'h0001, {15'h0000, cmax > period});
    // trigger landing on ffff zeroes the count without an overflow
    period <= 16'hFFFF;
    wr(OFF_COUNT_HIGH, 8'hFF);
    wr(OFF_COUNT_LOW, 8'hF0);
    cfg.assign_two = 1'b1;
    wr(OFF_CONTROL, cfg);
    watch(40);
    check("trig_at_top", 16'h0001, {15'h0000, count < 16'h0040});
    rd("trig_no_flag", OFF_FLAG_TWO, 8'h00);
    cmp_en <= 1'b0;
    $display("test trigger done");
    // pin sources: external pin, then oscillator pin
    cfg = '0;
    wr(OFF_CONTROL, cfg);
    wr(OFF_COUNT_HIGH, 8'h00);
    wr(OFF_COUNT_LOW, 8'h00);
    cfg.ext_sel = 1'b1;
    cfg.run_en = 1'b1;
    wr(OFF_CONTROL, cfg);
    pulses(1'b1, 1'b1, 6);
    check("ext_pin", 16'h0006, count);
    wr(OFF_AUX_CONTROL, 8'h08);
    pulses(1'b1, 1'b0, 3);
    check("ext_ignored", 16'h0006, count);
    pulses(1'b0, 1'b1, 4);
    check("osc_pin", 16'h000A, count);
    $display("test pins done");
    // compare one trigger, first against a coinciding write, then alone
    cfg = '0;
    cfg.assign_one = 1'b1;
    wr(OFF_CONTROL, cfg);
    wr(OFF_COUNT_HIGH, 8'h00);
    c1_mode <= TRIGGER_MODE;
    fork
      wr(OFF_COUNT_LOW, 8'h66);
      begin
        @(posedge clk_i);
        c1_trig <= 1'b1;
        @(posedge clk_i);
        c1_trig <= 1'b0;
      end
    join
    check("write_wins", 16'h0066, count);
    c1_trig <= 1'b1;
    @(posedge clk_i);
    c1_trig <= 1'b0;
    repeat (2) @(posedge clk_i);
    check("trig_one", 16'h0000, count);
    $display("test compare one done");
    summarize();
  end
endmodule
